// ==== testbench/sctp_port_properties.sv ====
// Purpose: Timing relations at the pins of the serial configuration test port
// Assumes: Test pins move on core_clk edges; ages count core cycles since raw pin edges
// Notes:   Windows allow two synchroniser flops, an edge detect and an output flop
`timescale 1ns/1ns
module sctp_port_properties
  import sctp_pkg::*;
(
  // Clock and reset
  input wire logic                  core_clk,
  input wire logic                  reset,
  // Watched pins
  input wire logic                  tck,
  input wire logic                  tms,
  input wire logic                  tdo_out,
  input wire logic                  tdo_oe_n,
  input wire logic [NVM_CMD_W-1:0]  nvm_cmd,
  input wire logic                  nvm_start,
  input wire logic [5:0]            nvm_instr,
  input wire logic [MAX_DR_LEN-1:0] nvm_data,
  input wire logic                  safe_state
);
  logic       tck_reg;
  logic [3:0] rise_age;
  logic [3:0] fall_age;
  logic       tms_at_rise;
  logic [2:0] hi_cnt;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);

  // Ages saturate, so a late output change stands out however long the clock idles
  always_ff @(posedge core_clk)
  begin
    tck_reg <= tck;
    if (reset)
    begin
      rise_age <= 4'hf;
      fall_age <= 4'hf;
    end
    else
    begin
      rise_age <= (tck && !tck_reg) ? 4'h0 : rise_age + {3'h0, rise_age != 4'hf};
      fall_age <= (!tck && tck_reg) ? 4'h0 : fall_age + {3'h0, fall_age != 4'hf};
    end
  end

  // Mode level at each raw rising edge and run of high levels
  always_ff @(posedge core_clk)
  begin
    if (reset)
      hi_cnt <= 3'h0;
    else if (tck && !tck_reg)
      hi_cnt <= tms ? hi_cnt + {2'h0, hi_cnt != 3'h5} : 3'h0;
    if (tck && !tck_reg)
      tms_at_rise <= tms;
  end

  property p_reset_out;
    $fell(reset) |-> tdo_oe_n && !nvm_start && nvm_cmd == NVM_NONE &&
      nvm_instr == INS_IDCODE && !safe_state;
  endproperty
  a_reset_out: assert property (p_reset_out) else $error("outputs wrong after reset");
  property p_start_pulse;
    nvm_start |=> !nvm_start;
  endproperty
  a_start_pulse: assert property (p_start_pulse) else $error("start longer than one cycle");
  property p_start_cmd;
    nvm_start |-> nvm_cmd != NVM_NONE && rise_age <= 4'h5;
  endproperty
  a_start_cmd: assert property (p_start_cmd) else $error("start without command or edge");
  property p_tdo_fall;
    $changed(tdo_out) |-> fall_age <= 4'h5;
  endproperty
  a_tdo_fall: assert property (p_tdo_fall) else $error("serial output moved off falling edge");
  property p_oe_fall;
    $changed(tdo_oe_n) |-> fall_age <= 4'h5;
  endproperty
  a_oe_fall: assert property (p_oe_fall) else $error("output enable moved off falling edge");
  property p_shift_entry;
    $fell(tdo_oe_n) |-> !tms_at_rise;
  endproperty
  a_shift_entry: assert property (p_shift_entry) else $error("shift entered with mode high");
  property p_data_upd;
    $changed(nvm_data) |-> rise_age <= 4'h5;
  endproperty
  a_data_upd: assert property (p_data_upd) else $error("data changed off rising edge");
  property p_instr_upd;
    $changed(nvm_instr) |-> rise_age <= 4'h5;
  endproperty
  a_instr_upd: assert property (p_instr_upd) else $error("instruction changed off edge");
  property p_tms_reset;
    $rose(hi_cnt == 3'h5) |-> ##[0:6] (tdo_oe_n && nvm_instr == INS_IDCODE);
  endproperty
  a_tms_reset: assert property (p_tms_reset) else $error("five high edges did not reset");
endmodule : sctp_port_properties

bind sctp_port sctp_port_properties i_sctp_port_properties (
  .core_clk   (core_clk),
  .reset      (reset),
  .tck        (tck),
  .tms        (tms),
  .tdo_out    (tdo_out),
  .tdo_oe_n   (tdo_oe_n),
  .nvm_cmd    (nvm_cmd),
  .nvm_start  (nvm_start),
  .nvm_instr  (nvm_instr),
  .nvm_data   (nvm_data),
  .safe_state (safe_state)
);

// ==== testbench/sctp_port_tb_top.sv ====
// Purpose: Self-checking bench for the serial configuration test port
// Assumes: Programmer model alone on the chain, 10 MHz core clock
// Notes:   Driver queues expected bits, a monitor pops them as bits are captured
`timescale 1ns/1ns
module sctp_port_tb_top
  import sctp_pkg::*;
;
  localparam logic [ID_LEN-1:0] TB_ID = 32'h3c96e12b; // Arbitrary identity value
  logic                  core_clk = 1'b0;
  logic                  reset = 1'b1;
  logic                  tck, tms, tdi, tdo_out, tdo_oe_n, seen_stb, seen_bit;
  logic [STAT_LEN-1:0]   comp_status = 12'h000;
  logic [MAX_DR_LEN-1:0] nvm_rdata = '0;
  logic [MAX_DR_LEN-1:0] nvm_data;
  logic [2:0]            nvm_cmd;
  logic [5:0]            nvm_instr;
  logic                  nvm_start, safe_state, exp_bit, mute = 1'b0;
  logic [8:0]            exp_nvm;
  logic                  bit_q[$];
  logic [8:0]            nvm_q[$];
  int                    err_count = 0;
  int                    samples_checked = 0;
  int                    seed = 96999;

  always #50 core_clk = ~core_clk;

  sctp_port #(.ID_VALUE(TB_ID)) i_sctp_port (.core_clk(core_clk), .reset(reset), .tck(tck),
    .tms(tms), .tdi(tdi), .tdo_out(tdo_out), .tdo_oe_n(tdo_oe_n), .comp_status(comp_status),
    .nvm_cmd(nvm_cmd), .nvm_start(nvm_start), .nvm_instr(nvm_instr), .nvm_data(nvm_data),
    .nvm_rdata(nvm_rdata), .safe_state(safe_state));
  // Model sits alone on its serial chain
  sctp_prog_model i_sctp_prog_model (.core_clk(core_clk), .tck(tck), .tms(tms), .tdi(tdi),
    .tdo_out(tdo_out), .tdo_oe_n(tdo_oe_n), .seen_stb(seen_stb), .seen_bit(seen_bit));

  task automatic check(input logic [MAX_DR_LEN-1:0] seen, input logic [MAX_DR_LEN-1:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      err_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic final_report;
    $display("Checks %0d, mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : final_report

  function automatic logic rbit();
    return ($random(seed) % 2) != 0;
  endfunction : rbit

  function automatic logic [MAX_DR_LEN-1:0] r81();
    logic [95:0] t;
    t = {$random(seed), $random(seed), $random(seed)};
    return t[MAX_DR_LEN-1:0];
  endfunction : r81

  task automatic tk(input logic m, input logic d);
    i_sctp_prog_model.clk_bit(m, d);
  endtask : tk

  // Idle to idle scan; idle clocks carry random data, optional pause after bit pz-1
  task automatic scan(input logic ir, input int n, input logic [MAX_DR_LEN-1:0] din,
                      input logic [MAX_DR_LEN-1:0] exp, input int pz);
    tk(1'b1, rbit());
    if (ir)
      tk(1'b1, rbit());
    tk(1'b0, rbit());
    tk(1'b0, rbit());
    for (int i = 0; i < n; i++)
    begin
      bit_q.push_back(exp[i]);
      tk(i == n - 1 || i == pz - 1, din[i]);
      if (i == pz - 1)
      begin
        repeat (3) tk(1'b0, rbit());
        tk(1'b1, rbit());
        tk(1'b0, rbit());
      end
    end
    tk(1'b1, rbit());
    tk(1'b0, rbit());
    // The port acts on the last rising edge a few core cycles after the pin moves
    repeat (2) @(posedge core_clk);
  endtask : scan

  task automatic ir_load(input logic [5:0] code);
    scan(1'b1, IR_LEN, MAX_DR_LEN'(code), MAX_DR_LEN'(IR_CAPTURE), 0);
  endtask : ir_load

  // Monitor pops the oldest note whenever a bit or a memory start appears
  always @(posedge core_clk)
  begin
    if (seen_stb)
    begin
      exp_bit = bit_q.pop_front();
      if (!mute)
        check(seen_bit, exp_bit);
    end
    if (nvm_start === 1'b1)
    begin
      exp_nvm = nvm_q.pop_front();
      check({nvm_cmd, nvm_instr}, exp_nvm);
    end
  end

  // Main sequence
  initial
  begin
    logic [MAX_DR_LEN-1:0] d;
    logic [5:0]            byp [6];
    logic [8:0]            mem [3];
    byp = '{INS_BYPASS, INS_EXTEST, INS_SAMPLE, 6'h3f, {1'b1, 5'(r81())}, 6'h09};
    mem = '{{NVM_ERASE, INS_ERASE_ALL}, {NVM_PROG, INS_PROG_CFG}, {NVM_READ, INS_READ_CFG}};
    repeat (2) @(posedge core_clk);
    reset <= 1'b0;
    tk(1'b0, 1'b0);
    scan(1'b0, ID_LEN, r81(), TB_ID, 10);
    $display("Test blind identity done");
    foreach (byp[k])
    begin
      d = r81();
      ir_load(byp[k]);
      scan(1'b0, 8, d, {d[MAX_DR_LEN-2:0], 1'b0}, 0);
    end
    $display("Test bypass codes done");
    comp_status <= STAT_LEN'(r81());
    nvm_rdata <= r81();
    ir_load(INS_STATUS);
    check(safe_state, 1'b0);
    scan(1'b0, STAT_LEN, r81(), MAX_DR_LEN'(comp_status), 0);
    $display("Test status done");
    mute = 1'b1;
    ir_load(INS_ADDR_CFG);
    scan(1'b0, LEN_ADDR_CFG, 81'h3, '0, 0);
    mute = 1'b0;
    d = r81();
    ir_load(INS_DATA_CFG);
    check(safe_state, 1'b1);
    scan(1'b0, LEN_DATA_CFG, d, nvm_rdata, 0);
    check(nvm_data[LEN_DATA_CFG-1:0], d[LEN_DATA_CFG-1:0]);
    foreach (mem[k])
    begin
      nvm_q.push_back(mem[k]);
      ir_load(mem[k][5:0]);
    end
    nvm_q.push_back(mem[2]);
    scan(1'b0, LEN_DATA_CFG, r81(), nvm_rdata, 0);
    $display("Test memory operations done");
    ir_load(INS_BYPASS);
    tk(1'b1, 1'b0);
    tk(1'b0, 1'b0);
    tk(1'b0, 1'b0);
    bit_q.push_back(1'b0);
    repeat (5) tk(1'b1, rbit());
    tk(1'b0, 1'b0);
    scan(1'b0, ID_LEN, r81(), TB_ID, 0);
    repeat (20) @(posedge core_clk);
    check(MAX_DR_LEN'(bit_q.size()), '0);
    check(MAX_DR_LEN'(nvm_q.size()), '0);
    $display("Test mode reset done");
    final_report();
  end

  // Watchdog well beyond the few thousand cycles the tests need
  initial
  begin
    repeat (20000) @(posedge core_clk);
    err_count++;
    $display("Error at %0t: watchdog expired", $time);
    final_report();
  end
endmodule : sctp_port_tb_top

// ==== testbench/sctp_prog_model.sv ====
// Purpose: Programmer model that clocks the test pins and captures the serial output
// Assumes: 800 ns test clock, low five core cycles and high three
// Notes:   Test clock stands high between calls; a released output reads as pulled up
`timescale 1ns/1ns
module sctp_prog_model
(
  // Clock
  input  wire logic core_clk,
  // Test pins
  output logic      tck,
  output logic      tms,
  output logic      tdi,
  input  wire logic tdo_out,
  input  wire logic tdo_oe_n,
  // Captured bit
  output logic      seen_stb,
  output logic      seen_bit
);
  // Mode high at start keeps the port in its reset state
  initial
  begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
    seen_stb = 1'b0;
    seen_bit = 1'b0;
  end

  // One test clock period; inputs settle while low and hold through the rising edge
  task automatic clk_bit(input logic m, input logic d);
    @(posedge core_clk);
    tck <= 1'b0;
    tms <= m;
    tdi <= d;
    repeat (5) @(posedge core_clk);
    tck      <= 1'b1;
    seen_stb <= !tdo_oe_n;
    seen_bit <= tdo_oe_n ? 1'b1 : tdo_out;
    @(posedge core_clk);
    seen_stb <= 1'b0;
    @(posedge core_clk);
  endtask : clk_bit
endmodule : sctp_prog_model

// ==== verilog/sctp_fsm.sv ====
// Purpose: Sixteen-state test port controller stepped on sampled rising test clock edges
// Assumes: rise is a one-cycle pulse, mode is already synchronised
// Notes:   State outputs describe the state the controller is in
`timescale 1ns/1ns
module sctp_fsm
  import sctp_pkg::*;
(
  // Clock and reset
  input  wire logic core_clk,
  input  wire logic reset,
  // Sampled link
  input  wire logic rise,
  input  wire logic mode,
  // Strobes
  sctp_tap_if.ctrl  tap
);

  typedef enum logic [15:0] {
    ST_TLR   = 16'h0001, ST_IDLE  = 16'h0002, ST_SELDR = 16'h0004, ST_CAPDR = 16'h0008,
    ST_SHDR  = 16'h0010, ST_EX1DR = 16'h0020, ST_PSDR  = 16'h0040, ST_EX2DR = 16'h0080,
    ST_UPDR  = 16'h0100, ST_SELIR = 16'h0200, ST_CAPIR = 16'h0400, ST_SHIR  = 16'h0800,
    ST_EX1IR = 16'h1000, ST_PSIR  = 16'h2000, ST_EX2IR = 16'h4000, ST_UPIR  = 16'h8000
  } sctp_state_t;

  sctp_state_t state_reg;
  sctp_state_t state_next;

  // Standard state graph; only reset holds with mode high
  always_comb
  begin
    case (state_reg)
      ST_TLR:   state_next = mode ? ST_TLR   : ST_IDLE;
      ST_IDLE:  state_next = mode ? ST_SELDR : ST_IDLE;
      ST_SELDR: state_next = mode ? ST_SELIR : ST_CAPDR;
      ST_CAPDR: state_next = mode ? ST_EX1DR : ST_SHDR;
      ST_SHDR:  state_next = mode ? ST_EX1DR : ST_SHDR;
      ST_EX1DR: state_next = mode ? ST_UPDR  : ST_PSDR;
      ST_PSDR:  state_next = mode ? ST_EX2DR : ST_PSDR;
      ST_EX2DR: state_next = mode ? ST_UPDR  : ST_SHDR;
      ST_UPDR:  state_next = mode ? ST_SELDR : ST_IDLE;
      ST_SELIR: state_next = mode ? ST_TLR   : ST_CAPIR;
      ST_CAPIR: state_next = mode ? ST_EX1IR : ST_SHIR;
      ST_SHIR:  state_next = mode ? ST_EX1IR : ST_SHIR;
      ST_EX1IR: state_next = mode ? ST_UPIR  : ST_PSIR;
      ST_PSIR:  state_next = mode ? ST_EX2IR : ST_PSIR;
      ST_EX2IR: state_next = mode ? ST_UPIR  : ST_SHIR;
      ST_UPIR:  state_next = mode ? ST_SELDR : ST_IDLE;
      default:  state_next = ST_TLR;
    endcase
  end

  // Advance only on a test clock rising edge
  always_ff @(posedge core_clk)
  begin
    if (reset)
      state_reg <= ST_TLR;
    else if (rise)
      state_reg <= state_next;
  end

  // State decodes; the datapath acts on them at the next rising edge, the output flops at the falling edge, and nvm_instr and safe_state follow tlr at once
  assign tap.tlr    = (state_reg == ST_TLR);
  assign tap.idle   = (state_reg == ST_IDLE);
  assign tap.cap_dr = (state_reg == ST_CAPDR);
  assign tap.sh_dr  = (state_reg == ST_SHDR);
  assign tap.upd_dr = (state_reg == ST_UPDR);
  assign tap.cap_ir = (state_reg == ST_CAPIR);
  assign tap.sh_ir  = (state_reg == ST_SHIR);
  assign tap.upd_ir = (state_reg == ST_UPIR);
  assign tap.drive  = (state_reg == ST_SHDR) || (state_reg == ST_SHIR);

endmodule : sctp_fsm

// ==== verilog/sctp_pkg.sv ====
// Purpose: Constants and types shared by the serial configuration test port
// Assumes: Six-bit instruction codes, 32-bit identification register
// Notes:   Data register lengths follow the instruction table of the port
package sctp_pkg;

  localparam int IR_LEN      = 6;
  localparam int ID_LEN      = 32;
  localparam int STAT_LEN    = 12;
  localparam int MAX_DR_LEN  = 81;
  localparam int NVM_CMD_W   = 3;

  // Instruction codes
  localparam logic [5:0] INS_EXTEST    = 6'h00;
  localparam logic [5:0] INS_ADDR_ARR  = 6'h01;
  localparam logic [5:0] INS_DATA_ARR  = 6'h02;
  localparam logic [5:0] INS_ERASE_AND = 6'h03;
  localparam logic [5:0] INS_ERASE_ARC = 6'h04;
  localparam logic [5:0] INS_PROG_ARR  = 6'h05;
  localparam logic [5:0] INS_PROG_FUSE = 6'h06;
  localparam logic [5:0] INS_BYPASS    = 6'h07;
  localparam logic [5:0] INS_READ_ARR  = 6'h08;
  localparam logic [5:0] INS_ADDR_CFG  = 6'h0a;
  localparam logic [5:0] INS_DATA_CFG  = 6'h0b;
  localparam logic [5:0] INS_ERASE_CFG = 6'h0c;
  localparam logic [5:0] INS_PROG_CFG  = 6'h0d;
  localparam logic [5:0] INS_READ_CFG  = 6'h0e;
  localparam logic [5:0] INS_ERASE_ALL = 6'h16;
  localparam logic [5:0] INS_IDCODE    = 6'h19;
  localparam logic [5:0] INS_STATUS    = 6'h1b;
  localparam logic [5:0] INS_SAMPLE    = 6'h1c;
  localparam logic [5:0] INS_ERASE_UES = 6'h1d;
  localparam logic [5:0] INS_SHIFT_UES = 6'h1e;
  localparam logic [5:0] INS_PROG_UES  = 6'h1f;

  // Data register lengths
  localparam int LEN_ADDR_ARR = 75;
  localparam int LEN_DATA_ARR = 81;
  localparam int LEN_ADDR_CFG = 4;
  localparam int LEN_DATA_CFG = 41;
  localparam int LEN_UES      = 16;

  // Capture pattern of the instruction stage: two low bits fixed at 01
  localparam logic [5:0] IR_CAPTURE = INS_IDCODE;

  // Commands handed to the non-volatile memory controller
  localparam logic [2:0] NVM_NONE  = 3'h0;
  localparam logic [2:0] NVM_ERASE = 3'h1;
  localparam logic [2:0] NVM_PROG  = 3'h2;
  localparam logic [2:0] NVM_READ  = 3'h3;

  // Selected data path
  typedef enum logic [6:0] {
    SEL_BYPASS = 7'h01,
    SEL_ID     = 7'h02,
    SEL_STAT   = 7'h04,
    SEL_ADDR_A = 7'h08,
    SEL_DATA_A = 7'h10,
    SEL_ADDR_C = 7'h20,
    SEL_DATA_C = 7'h40
  } sctp_sel_t;

endpackage : sctp_pkg

// ==== verilog/sctp_port.sv ====
// Purpose: Serial configuration test access port top level
// Assumes: Test pins are asynchronous to core_clk and sampled at 10 MHz
// Notes:   Non-volatile memory is outside; this port issues commands and data to it
//
// Operation
// - Port is a serial configuration interface only; no boundary-scan cells exist.
// - One-bit bypass register links serial input to output when selected.
// - Boundary-scan instructions select bypass instead.
// - Identification register plus six manufacturer data registers are provided.
// - Status register reads the twelve comparator outputs.
// - Inputs sampled on rising test clock, output changes on falling edge.
// - Sixteen-state controller steps on rising test clock by mode-select.
// - Six stable states; only reset state holds with mode-select high.
// - Five rising edges with mode-select high reach reset state.
// - Power-on enters reset state; leaving it goes to idle.
// - Idle does nothing unless a memory operation instruction is loaded.
// - Data capture loads the selected register in parallel.
// - Instruction capture loads the identification instruction pattern.
// - Identification register is selected by default after reset.
// - Capture, shift, exit, pause and update follow the standard path.
// - Pause states hold register contents without shifting.
// - Program, erase and verify start at the first rising edge spent in idle after an update.
// - All other instructions take effect in the update state.
// - Configuration data registers can be shifted out to verify.
// - Instruction register is six bits long.
// - Code 000111 and any code with top bit set select bypass.
// - Code 011001 selects the 32-bit identification register.
`timescale 1ns/1ns
module sctp_port
  import sctp_pkg::*;
#(
  parameter logic [ID_LEN-1:0] ID_VALUE = 32'h0a5a5001  // Arbitrary neutral identity
)
(
  // Clock and reset
  input  wire logic                    core_clk,
  input  wire logic                    reset,
  // Test pins
  input  wire logic                    tck,
  input  wire logic                    tms,
  input  wire logic                    tdi,
  output logic                         tdo_out,
  output logic                         tdo_oe_n,
  // Comparator outputs
  input  wire logic [STAT_LEN-1:0]     comp_status,
  // Non-volatile memory side
  output logic [NVM_CMD_W-1:0]         nvm_cmd,
  output logic                         nvm_start,
  output logic [5:0]                   nvm_instr,
  output logic [MAX_DR_LEN-1:0]        nvm_data,
  input  wire logic [MAX_DR_LEN-1:0]   nvm_rdata,
  // Output mode
  output logic                         safe_state
);

  sctp_tap_if tap();

  // Two-flop synchronisers for pins and comparators
  logic [2:0]          pin_s1_reg;
  logic [2:0]          pin_s2_reg;
  logic                tck_d_reg;
  logic [STAT_LEN-1:0] comp_s1_reg;
  logic [STAT_LEN-1:0] comp_s2_reg;

  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      pin_s1_reg  <= 3'h0;
      pin_s2_reg  <= 3'h0;
      tck_d_reg   <= 1'b0;
      comp_s1_reg <= '0;
      comp_s2_reg <= '0;
    end
    else
    begin
      pin_s1_reg  <= {tck, tms, tdi};
      pin_s2_reg  <= pin_s1_reg;
      tck_d_reg   <= pin_s2_reg[2];
      comp_s1_reg <= comp_status;
      comp_s2_reg <= comp_s1_reg;
    end
  end

  logic rise;
  logic fall;
  logic tms_s;
  logic tdi_s;
  assign rise  =  pin_s2_reg[2] & ~tck_d_reg;
  assign fall  = ~pin_s2_reg[2] &  tck_d_reg;
  assign tms_s = pin_s2_reg[1];
  assign tdi_s = pin_s2_reg[0];

  sctp_fsm u_fsm (
    .core_clk (core_clk),
    .reset    (reset),
    .rise     (rise),
    .mode     (tms_s),
    .tap      (tap.ctrl)
  );

  // Instruction shift stage and active instruction
  logic [IR_LEN-1:0] ir_sh_reg;
  logic [IR_LEN-1:0] ir_reg;

  always_ff @(posedge core_clk)
  begin
    if (reset)
      ir_sh_reg <= 6'h00;
    else if (rise && tap.cap_ir)
      ir_sh_reg <= IR_CAPTURE;
    else if (rise && tap.sh_ir)
      ir_sh_reg <= {tdi_s, ir_sh_reg[IR_LEN-1:1]};
  end

  // Active instruction changes only in update or reset
  always_ff @(posedge core_clk)
  begin
    if (reset)
      ir_reg <= INS_IDCODE;
    else if (rise && tap.tlr)
      ir_reg <= INS_IDCODE;
    else if (rise && tap.upd_ir)
      ir_reg <= ir_sh_reg;
  end

  // Data path selection; no boundary register exists at all
  sctp_sel_t  sel;
  logic [6:0] dr_len;
  always_comb
  begin
    sel    = SEL_BYPASS;
    dr_len = 7'h01;
    if (ir_reg[IR_LEN-1] || ir_reg == INS_BYPASS)
    begin
      sel    = SEL_BYPASS;
      dr_len = 7'h01;
    end
    else
    begin
      case (ir_reg)
        INS_IDCODE:   begin sel = SEL_ID;     dr_len = 7'(ID_LEN);       end
        INS_STATUS:   begin sel = SEL_STAT;   dr_len = 7'(STAT_LEN);     end
        INS_ADDR_ARR: begin sel = SEL_ADDR_A; dr_len = 7'(LEN_ADDR_ARR); end
        INS_DATA_ARR,
        INS_READ_ARR: begin sel = SEL_DATA_A; dr_len = 7'(LEN_DATA_ARR); end
        INS_ADDR_CFG: begin sel = SEL_ADDR_C; dr_len = 7'(LEN_ADDR_CFG); end
        INS_DATA_CFG,
        INS_READ_CFG: begin sel = SEL_DATA_C; dr_len = 7'(LEN_DATA_CFG); end
        INS_SHIFT_UES: begin sel = SEL_DATA_C; dr_len = 7'(LEN_UES);     end
        default:      begin sel = SEL_BYPASS; dr_len = 7'h01;            end
      endcase
    end
  end

  // Parallel capture value per selected path
  logic [MAX_DR_LEN-1:0] cap_val;
  logic [MAX_DR_LEN-1:0] dr_q;
  always_comb
  begin
    case (sel)
      SEL_ID:   cap_val = MAX_DR_LEN'(ID_VALUE);
      SEL_STAT: cap_val = MAX_DR_LEN'(comp_s2_reg);
      SEL_DATA_A,
      SEL_DATA_C: cap_val = nvm_rdata;
      SEL_BYPASS: cap_val = '0;
      default:  cap_val = dr_q;
    endcase
  end

  // One shared shift array; pause states neither load nor shift
  sctp_shreg #(.W(MAX_DR_LEN)) u_dr (
    .core_clk (core_clk),
    .reset    (reset),
    .load     (rise && tap.cap_dr),
    .shift    (rise && tap.sh_dr),
    .len      (dr_len),
    .din      (tdi_s),
    .pdata    (cap_val),
    .q        (dr_q)
  );

  // Output changes on falling edge, released outside shift states
  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      tdo_out  <= 1'b0;
      tdo_oe_n <= 1'b1;
    end
    else if (fall)
    begin
      tdo_out  <= tap.sh_ir ? ir_sh_reg[0] : dr_q[0];
      tdo_oe_n <= ~tap.drive;
    end
  end

  // Memory operations decoded from the active instruction
  logic is_mem_op;
  logic [NVM_CMD_W-1:0] mem_kind;
  always_comb
  begin
    is_mem_op = 1'b1;
    mem_kind  = NVM_NONE;
    case (ir_reg)
      INS_ERASE_AND, INS_ERASE_ARC, INS_ERASE_CFG,
      INS_ERASE_ALL, INS_ERASE_UES: mem_kind = NVM_ERASE;
      INS_PROG_ARR, INS_PROG_FUSE, INS_PROG_CFG,
      INS_PROG_UES:                 mem_kind = NVM_PROG;
      INS_READ_ARR, INS_READ_CFG:   mem_kind = NVM_READ;
      default:                      is_mem_op = 1'b0;
    endcase
  end

  // Arm on instruction update, fire at the first rising edge taken in idle after an update
  logic armed_reg;
  always_ff @(posedge core_clk)
  begin
    if (reset)
      armed_reg <= 1'b0;
    else if (rise && tap.upd_ir)
      armed_reg <= 1'b1;
    else if (rise && tap.tlr)
      armed_reg <= 1'b0;
  end

  // Start pulse is one core cycle, after update with the controller now in idle
  logic upd_seen_reg;
  always_ff @(posedge core_clk)
  begin
    if (reset)
      upd_seen_reg <= 1'b0;
    else if (rise)
      upd_seen_reg <= tap.upd_ir || tap.upd_dr;
  end

  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      nvm_start <= 1'b0;
      nvm_cmd   <= NVM_NONE;
    end
    else
    begin
      nvm_start <= 1'b0;
      if (rise && tap.idle && upd_seen_reg && armed_reg && is_mem_op)
      begin
        nvm_start <= 1'b1;
        nvm_cmd   <= mem_kind;
      end
    end
  end

  // Manufacturer codes other than INS_STATUS, INS_SHIFT_UES and 6'h1a park the outputs in their safe state while they are active
  logic safe_code;
  always_comb
  begin
    safe_code = 1'b1;
    if (ir_sh_reg[IR_LEN-1])
      safe_code = 1'b0;
    else
    begin
      case (ir_sh_reg)
        INS_BYPASS,
        INS_IDCODE,
        INS_STATUS,
        INS_SAMPLE,
        INS_EXTEST,
        INS_SHIFT_UES,
        6'h1a:   safe_code = 1'b0;                      // Program-disable returns normal IO
        default: safe_code = 1'b1;
      endcase
    end
  end

  // Data register contents handed over at Update-DR
  always_ff @(posedge core_clk)
  begin
    if (reset)
      nvm_data <= '0;
    else if (rise && tap.upd_dr)
      nvm_data <= dr_q;
  end

  // Instruction handed over at Update-IR; the reset state falls back to
  // identification at once, so a programmer that parks the test clock right
  // after five high edges still leaves the memory side in functional mode
  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      nvm_instr  <= INS_IDCODE;
      safe_state <= 1'b0;
    end
    else if (tap.tlr)
    begin
      nvm_instr  <= INS_IDCODE;
      safe_state <= 1'b0;
    end
    else if (rise && tap.upd_ir)
    begin
      nvm_instr  <= ir_sh_reg;
      safe_state <= safe_code;
    end
  end

endmodule : sctp_port

// ==== verilog/sctp_shreg.sv ====
// Purpose: Parallel-load serial shift register used for every data path
// Assumes: Shifts toward bit zero, serial input enters the top of the active length
// Notes:   Length chooses which bit takes the serial input, so one flop array serves all
`timescale 1ns/1ns
module sctp_shreg
  import sctp_pkg::*;
#(
  parameter int W = MAX_DR_LEN
)
(
  // Clock and reset
  input  wire logic         core_clk,
  input  wire logic         reset,
  // Control
  input  wire logic         load,
  input  wire logic         shift,
  input  wire logic [6:0]   len,
  input  wire logic         din,
  input  wire logic [W-1:0] pdata,
  // Contents
  output logic      [W-1:0] q
);

  logic [W-1:0] q_reg;
  logic [W-1:0] q_next;

  // Shift right; serial bit lands at len-1
  always_comb
  begin
    q_next = q_reg;
    if (load)
      q_next = pdata;
    else if (shift)
    begin
      q_next = q_reg >> 1;
      q_next[len - 7'h01] = din;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (reset)
      q_reg <= '0;
    else
      q_reg <= q_next;
  end

  assign q = q_reg;

endmodule : sctp_shreg

// ==== verilog/sctp_tap_if.sv ====
// Purpose: Carries controller state strobes from the state machine to the datapath
// Assumes: Strobes are state decodes, high for every core clock the controller spends in that state
// Notes:   The state machine drives, the main module listens
`timescale 1ns/1ns
interface sctp_tap_if;
  logic tlr;
  logic idle;
  logic cap_dr;
  logic sh_dr;
  logic upd_dr;
  logic cap_ir;
  logic sh_ir;
  logic upd_ir;
  logic drive;

  modport ctrl (output tlr, idle, cap_dr, sh_dr, upd_dr, cap_ir, sh_ir, upd_ir, drive);
  modport dp   (input  tlr, idle, cap_dr, sh_dr, upd_dr, cap_ir, sh_ir, upd_ir, drive);
endinterface : sctp_tap_if
